// *** rtl/acsu_top.sv ***
/*
  atomic compare-and-swap unit: takes one instruction with its operands,
  checks it, then runs a locked load followed by an unconditional store.
  assumes a memory port on the same clock that answers each request with a
  one-cycle ack and honours the lock for the whole doubleword.
*/
`timescale 1ns/1ps
module acsu_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [31:0] instr_i,
  input wire logic [acsu_pkg::XLEN-1:0] address_source_reg_i,
  input wire logic [acsu_pkg::XLEN-1:0] compare_source_reg_i,
  input wire logic [acsu_pkg::XLEN-1:0] dest_reg_i,
  input wire logic [7:0] space_reg_i,
  input wire logic priv_i,
  output logic busy_o,
  output logic atomic_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic mem_dw_o,
  output logic mem_lock_o,
  output logic [acsu_pkg::ALEN-1:0] mem_addr_o,
  output logic [7:0] mem_space_o,
  output logic [acsu_pkg::XLEN-1:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic mem_err_i,
  input wire logic [acsu_pkg::XLEN-1:0] mem_rdata_i,
  output logic done_o,
  output logic rd_we_o,
  output logic [acsu_pkg::RIDX-1:0] rd_idx_o,
  output logic [acsu_pkg::XLEN-1:0] rd_data_o,
  output logic match_o,
  output logic trap_o,
  output acsu_pkg::acsu_trap_t trap_code_o,
  output logic cc_we_o
);
  import acsu_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CHECK,
    ST_LOAD,
    ST_STORE
  } acsu_state_t;

  acsu_state_t state_q, state_d;
  logic [31:0] instr_q;
  logic [XLEN-1:0] addr_q, cmp_q, new_q, old_q;
  logic [7:0] space_q;
  logic priv_q;

  wire logic dec_cas, dec_dw;
  wire logic [7:0] dec_space;
  acsu_trap_t dec_trap;
  wire logic mg_match;
  wire logic [XLEN-1:0] mg_store, mg_old;

  acsu_decode u_decode (
    .instr_i(instr_q),
    .addr_i(addr_q),
    .space_reg_i(space_q),
    .priv_i(priv_q),
    .is_cas_o(dec_cas),
    .is_dw_o(dec_dw),
    .space_o(dec_space),
    .trap_o(dec_trap)
  );

  acsu_merge u_merge (
    .is_dw_i(mem_dw_o),
    .little_i(mem_space_o[SPACE_LITTLE_BIT]),
    .cmp_i(cmp_q),
    .new_i(new_q),
    .mem_i(mem_rdata_i),
    .match_o(mg_match),
    .store_o(mg_store),
    .old_o(mg_old)
  );

  wire logic start = (state_q == ST_IDLE) && req_i;
  // a non-cas opcode must never answer, not even with a trap
  wire logic check_trap = (state_q == ST_CHECK) && dec_cas && (dec_trap != TRAP_NONE);
  wire logic check_go = (state_q == ST_CHECK) && (dec_trap == TRAP_NONE);
  wire logic load_ack = (state_q == ST_LOAD) && mem_ack_i;
  wire logic load_ok = load_ack && !mem_err_i;
  wire logic store_ack = (state_q == ST_STORE) && mem_ack_i;
  wire logic finish = check_trap || (load_ack && mem_err_i) || store_ack;
  wire logic fail = check_trap || ((load_ack || store_ack) && mem_err_i);
  wire acsu_trap_t fail_code = check_trap ? dec_trap : TRAP_ACCESS;

  // non-cas opcodes are dropped in check without any answer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (req_i) begin
          state_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (!dec_cas || check_trap) begin
          state_d = ST_IDLE;
        end else begin
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (load_ack) begin
          state_d = mem_err_i ? ST_IDLE : ST_STORE;
        end
      end
      ST_STORE: begin
        if (store_ack) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // operands are captured once so the caller may move on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_q <= 32'h0;
      addr_q <= RST_ADDR;
      cmp_q <= RST_DATA;
      new_q <= RST_DATA;
      space_q <= RST_SPACE;
      priv_q <= 1'b0;
    end else if (start) begin
      instr_q <= instr_i;
      addr_q <= address_source_reg_i;
      cmp_q <= compare_source_reg_i;
      new_q <= dest_reg_i;
      space_q <= space_reg_i;
      priv_q <= priv_i;
    end
  end

  // busy spans check, load and store, atomic only load and store; the core holds interrupts
  // and deferred traps while atomic is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      atomic_o <= 1'b0;
    end else begin
      busy_o <= state_d != ST_IDLE;
      atomic_o <= (state_d == ST_LOAD) || (state_d == ST_STORE);
    end
  end

  // the lock covers the containing doubleword from load issue to store ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_lock_o <= 1'b0;
    end else begin
      mem_req_o <= (check_go && dec_cas) || load_ok || (mem_req_o && !mem_ack_i);
      mem_we_o <= load_ok || (mem_we_o && !store_ack);
      mem_lock_o <= (check_go && dec_cas) || (mem_lock_o && !finish);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_addr_o <= RST_ADDR;
      mem_space_o <= RST_SPACE;
      mem_dw_o <= 1'b0;
    end else if (check_go) begin
      mem_addr_o <= addr_q;
      mem_space_o <= dec_space;
      mem_dw_o <= dec_dw;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_wdata_o <= RST_DATA;
      old_q <= RST_DATA;
      match_o <= 1'b0;
    end else if (load_ok) begin
      mem_wdata_o <= mg_store;
      old_q <= mg_old;
      match_o <= mg_match;
    end
  end

  // results; the destination is written only after the store succeeds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      rd_we_o <= 1'b0;
      trap_o <= 1'b0;
      trap_code_o <= TRAP_NONE;
      rd_data_o <= RST_DATA;
      rd_idx_o <= '0;
    end else begin
      done_o <= finish;
      rd_we_o <= store_ack && !mem_err_i;
      trap_o <= fail;
      trap_code_o <= fail ? fail_code : TRAP_NONE;
      if (store_ack && !mem_err_i) begin
        rd_data_o <= old_q;
      end
      if (check_go) begin
        rd_idx_o <= instr_q[RD_HI:RD_LO];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cc_we_o <= 1'b0;
    end else begin
      cc_we_o <= 1'b0;
    end
  end

  sequence seq_load_done;
    mem_req_o && !mem_we_o && mem_ack_i && !mem_err_i;
  endsequence

  sequence seq_store_issue;
    mem_req_o && mem_we_o && mem_lock_o;
  endsequence

  wire logic [XLEN-1:0] mem_old = mg_old;

  chk_store_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_load_done |=> seq_store_issue)
    else $error("no store after a clean load");

  chk_match_data: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_load_done ##0 mg_match |=> mem_wdata_o == $past(mg_store) && match_o)
    else $error("match store data wrong");

  chk_miss_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_load_done ##0 !mg_match |=> !match_o && (mem_dw_o ? mem_wdata_o == $past(mem_rdata_i)
    : mem_wdata_o[WLEN-1:0] == $past(mem_rdata_i[WLEN-1:0])))
    else $error("miss store data changed");

  chk_word_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_we_o && !mem_dw_o |-> rd_data_o[XLEN-1:WLEN] == 32'h0)
    else $error("word result upper half not zero");

  chk_lock_span: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_req_o |-> mem_lock_o && atomic_o)
    else $error("memory access without lock");

  chk_illegal_form: assert property (@(posedge clk_i) disable iff (rst_i)
    start && instr_i[IFORM_BIT] && instr_i[IMM_HI:IMM_LO] != 8'h00
    && instr_i[OP_HI:OP_LO] == OP_MEMORY && instr_i[OP3_HI:OP3_LO] == OP3_CAS_WORD
    |-> ##2 done_o && trap_o && trap_code_o == TRAP_ILLEGAL && !mem_req_o)
    else $error("illegal form not trapped");

  chk_user_space: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_lock_o |-> priv_q || mem_space_o[SPACE_USER_BIT])
    else $error("user access to privileged space");

  chk_priv_range: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_lock_o && priv_q |-> mem_space_o < PRIV_ONLY_LO || mem_space_o > PRIV_ONLY_HI)
    else $error("privileged-only range accepted");

  chk_no_cc_write: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(done_o) |-> !cc_we_o ##1 !cc_we_o)
    else $error("condition codes written");

  chk_trap_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    trap_o |-> !rd_we_o && !mem_req_o && !atomic_o)
    else $error("trap with side effects");

  chk_dw_compare: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_load_done ##0 mem_dw_o && mem_old != cmp_q |=> !match_o)
    else $error("doubleword compare wrong");
endmodule

// *** common/acsu_pkg.sv ***
/*
  constants, field layout and trap codes of the atomic compare-and-swap unit.
  assumes a 64-bit integer datapath and a 32-bit instruction word.
*/
package acsu_pkg;
  localparam int XLEN = 64;
  localparam int WLEN = 32;
  localparam int ALEN = 64;
  localparam int RIDX = 5;

  localparam int OP_HI = 31;
  localparam int OP_LO = 30;
  localparam int RD_HI = 29;
  localparam int RD_LO = 25;
  localparam int OP3_HI = 24;
  localparam int OP3_LO = 19;
  localparam int IFORM_BIT = 13;
  localparam int IMM_HI = 12;
  localparam int IMM_LO = 5;

  localparam logic [1:0] OP_MEMORY = 2'h3;
  localparam logic [5:0] OP3_CAS_WORD = 6'h3c;
  localparam logic [5:0] OP3_CAS_DWORD = 6'h3e;

  localparam logic [7:0] KERNEL_SPACE = 8'h04;
  localparam logic [7:0] KERNEL_SPACE_LE = 8'h0c;
  localparam logic [7:0] USER_VIEW_PRIMARY_SPACE = 8'h10;
  localparam logic [7:0] USER_VIEW_SECONDARY_SPACE = 8'h11;
  localparam logic [7:0] REAL_SPACE = 8'h14;
  localparam logic [7:0] USER_VIEW_PRIMARY_SPACE_LE = 8'h18;
  localparam logic [7:0] USER_VIEW_SECONDARY_SPACE_LE = 8'h19;
  localparam logic [7:0] REAL_SPACE_LE = 8'h1c;
  localparam logic [7:0] PRIMARY_SPACE = 8'h80;
  localparam logic [7:0] SECONDARY_SPACE = 8'h81;
  localparam logic [7:0] PRIMARY_SPACE_LE = 8'h88;
  localparam logic [7:0] SECONDARY_SPACE_LE = 8'h89;
  localparam logic [7:0] PRIV_ONLY_LO = 8'h30;
  localparam logic [7:0] PRIV_ONLY_HI = 8'h7f;
  localparam int SPACE_USER_BIT = 7;
  localparam int SPACE_LITTLE_BIT = 3;

  localparam logic [XLEN-1:0] RST_DATA = 64'h0;
  localparam logic [ALEN-1:0] RST_ADDR = 64'h0;
  localparam logic [7:0] RST_SPACE = 8'h00;

  typedef enum logic [2:0] {
    TRAP_NONE,
    TRAP_ILLEGAL,
    TRAP_ALIGN,
    TRAP_PRIV,
    TRAP_ACCESS
  } acsu_trap_t;
endpackage

// *** rtl/acsu_decode.sv ***
/*
  instruction decode and legality checks for compare-and-swap.
  assumes registered operands from the caller; purely combinational.
*/
`timescale 1ns/1ps
module acsu_decode (
  input wire logic [31:0] instr_i,
  input wire logic [acsu_pkg::ALEN-1:0] addr_i,
  input wire logic [7:0] space_reg_i,
  input wire logic priv_i,
  output logic is_cas_o,
  output logic is_dw_o,
  output logic [7:0] space_o,
  output acsu_pkg::acsu_trap_t trap_o
);
  import acsu_pkg::*;

  function automatic logic space_allowed(input logic [7:0] s);
    case (s)
      KERNEL_SPACE, KERNEL_SPACE_LE,
      USER_VIEW_PRIMARY_SPACE, USER_VIEW_PRIMARY_SPACE_LE,
      USER_VIEW_SECONDARY_SPACE, USER_VIEW_SECONDARY_SPACE_LE,
      REAL_SPACE, REAL_SPACE_LE,
      PRIMARY_SPACE, PRIMARY_SPACE_LE,
      SECONDARY_SPACE, SECONDARY_SPACE_LE: space_allowed = 1'b1;
      default: space_allowed = 1'b0;
    endcase
  endfunction

  wire logic [5:0] op3 = instr_i[OP3_HI:OP3_LO];
  wire logic iform = instr_i[IFORM_BIT];
  wire logic [7:0] imm_space = instr_i[IMM_HI:IMM_LO];
  wire logic op_ok = instr_i[OP_HI:OP_LO] == OP_MEMORY;
  wire logic bad_form = iform && (imm_space != 8'h00);
  wire logic bad_align = is_dw_o ? (addr_i[2:0] != 3'h0) : (addr_i[1:0] != 2'h0);
  wire logic priv_fail = priv_i ? (space_o >= PRIV_ONLY_LO && space_o <= PRIV_ONLY_HI)
                                : !space_o[SPACE_USER_BIT];
  wire logic space_fail = !space_allowed(space_o);

  assign is_cas_o = op_ok && (op3 == OP3_CAS_WORD || op3 == OP3_CAS_DWORD);
  assign is_dw_o = op3 == OP3_CAS_DWORD;
  assign space_o = iform ? space_reg_i : imm_space;
  // privilege checks are taken before the space check
  assign trap_o = bad_form ? TRAP_ILLEGAL :
                  bad_align ? TRAP_ALIGN :
                  priv_fail ? TRAP_PRIV :
                  space_fail ? TRAP_ACCESS : TRAP_NONE;
endmodule

// *** rtl/acsu_merge.sv ***
/*
  compare and result selection for one compare-and-swap.
  assumes raw memory data in big-endian lane order, word data in the low half.
*/
`timescale 1ns/1ps
module acsu_merge (
  input wire logic is_dw_i,
  input wire logic little_i,
  input wire logic [acsu_pkg::XLEN-1:0] cmp_i,
  input wire logic [acsu_pkg::XLEN-1:0] new_i,
  input wire logic [acsu_pkg::XLEN-1:0] mem_i,
  output logic match_o,
  output logic [acsu_pkg::XLEN-1:0] store_o,
  output logic [acsu_pkg::XLEN-1:0] old_o
);
  import acsu_pkg::*;

  function automatic logic [XLEN-1:0] order(input logic dw, input logic le,
                                             input logic [XLEN-1:0] v);
    logic [XLEN-1:0] r;
    r = v;
    if (le) begin
      for (int b = 0; b < 8; b++) begin
        r[8*b +: 8] = v[8*(7-b) +: 8];
      end
      if (!dw) begin
        r = {32'h0, r[XLEN-1:WLEN]};
        r[WLEN-1:0] = {v[7:0], v[15:8], v[23:16], v[31:24]};
      end
    end
    if (!dw) begin
      r[XLEN-1:WLEN] = 32'h0;
    end
    order = r;
  endfunction

  wire logic [XLEN-1:0] keep;
  assign old_o = order(is_dw_i, little_i, mem_i);
  assign match_o = is_dw_i ? (old_o == cmp_i) : (old_o[WLEN-1:0] == cmp_i[WLEN-1:0]);
  // a miss writes the old value back so the access is always a store
  assign keep = match_o ? new_i : old_o;
  assign store_o = order(is_dw_i, little_i, keep);
endmodule

// *** bench/acsu_mem_model.sv ***
/*
  behavioural memory behind the unit's load-store port: sixteen 32-bit words,
  ack latency and load or store errors set by the bench.
  assumes the unit holds each request until the ack, on the same clock.
*/
`timescale 1ns/1ps
module acsu_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] lat_i,
  input wire logic err_ld_i,
  input wire logic err_st_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic mem_dw_i,
  input wire logic [63:0] mem_addr_i,
  input wire logic [63:0] mem_wdata_i,
  output logic mem_ack_o,
  output logic mem_err_o,
  output logic [63:0] mem_rdata_o
);
  logic [31:0] w [0:15];
  logic [3:0] wait_q;
  int stores = 0;
  wire [3:0] idx = mem_addr_i[5:2];
  wire [3:0] idx_lo = idx + 4'h1;
  // a single port, so nothing else can touch the locked doubleword meanwhile
  always @(posedge clk_i) begin
    mem_ack_o <= 1'b0;
    mem_err_o <= 1'b0;
    // idle data inverts every cycle so a late sample cannot pass by luck
    mem_rdata_o <= ~mem_rdata_o;
    if (rst_i) begin
      wait_q <= 4'h0;
      mem_rdata_o <= 64'h0;
    end else if (mem_req_i && !mem_ack_o && wait_q < lat_i) begin
      wait_q <= wait_q + 4'h1;
    end else if (mem_req_i && !mem_ack_o) begin
      wait_q <= 4'h0;
      mem_ack_o <= 1'b1;
      if (!mem_we_i) begin
        mem_err_o <= err_ld_i;
        mem_rdata_o <= mem_dw_i ? {w[idx], w[idx_lo]} : {32'h0, w[idx]};
      end else begin
        stores++;
        mem_err_o <= err_st_i;
        if (!err_st_i) begin
          w[idx] <= mem_dw_i ? mem_wdata_i[63:32] : mem_wdata_i[31:0];
          if (mem_dw_i) begin
            w[idx_lo] <= mem_wdata_i[31:0];
          end
        end
      end
    end
  end
endmodule

// *** bench/tb_top.sv ***
/*
  self-checking bench for the compare-and-swap unit and its memory model.
  assumes one-cycle requests while idle and a done pulse ending each compare-and-swap.
*/
`timescale 1ns/1ps
module tb_top;
  import acsu_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_i = 1'b0;
  logic [31:0] instr_i = 32'h0;
  logic [63:0] address_source_reg_i = 64'h0;
  logic [63:0] compare_source_reg_i = 64'h0;
  logic [63:0] dest_reg_i = 64'h0;
  logic [7:0] space_reg_i = 8'h00;
  logic priv_i = 1'b0;
  logic [3:0] lat = 4'h0;
  logic err_ld = 1'b0;
  logic err_st = 1'b0;
  logic busy_o, atomic_o, mem_req_o, mem_we_o, mem_dw_o, mem_lock_o;
  logic mem_ack_i, mem_err_i, done_o, rd_we_o, match_o, trap_o, cc_we_o;
  logic [63:0] mem_addr_o, mem_wdata_o, mem_rdata_i, rd_data_o;
  logic [7:0] mem_space_o;
  logic [4:0] rd_idx_o;
  acsu_trap_t trap_code_o;
  int failures = 0;
  int checked = 0;
  int s0;
  logic got_done, got_we, got_m, got_tf;
  logic [4:0] got_idx;
  logic [63:0] got_rd;
  acsu_trap_t got_trap;
  localparam logic [7:0] SPACES [12] = '{KERNEL_SPACE, KERNEL_SPACE_LE,
    USER_VIEW_PRIMARY_SPACE, USER_VIEW_PRIMARY_SPACE_LE, USER_VIEW_SECONDARY_SPACE,
    USER_VIEW_SECONDARY_SPACE_LE, REAL_SPACE, REAL_SPACE_LE, PRIMARY_SPACE,
    PRIMARY_SPACE_LE, SECONDARY_SPACE, SECONDARY_SPACE_LE};

  always #5 clk_i = ~clk_i;

  acsu_top dut (.clk_i, .rst_i, .req_i, .instr_i, .address_source_reg_i,
    .compare_source_reg_i, .dest_reg_i, .space_reg_i, .priv_i, .busy_o, .atomic_o,
    .mem_req_o, .mem_we_o, .mem_dw_o, .mem_lock_o, .mem_addr_o, .mem_space_o,
    .mem_wdata_o, .mem_ack_i, .mem_err_i, .mem_rdata_i, .done_o, .rd_we_o, .rd_idx_o,
    .rd_data_o, .match_o, .trap_o, .trap_code_o, .cc_we_o);

  acsu_mem_model mem (.clk_i, .rst_i, .lat_i(lat), .err_ld_i(err_ld), .err_st_i(err_st),
    .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_dw_i(mem_dw_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i),
    .mem_err_o(mem_err_i), .mem_rdata_o(mem_rdata_i));

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // every memory access must run locked and with interrupts held off
  always @(negedge clk_i) begin
    if (mem_req_o === 1'b1) begin
      check({atomic_o, mem_lock_o}, 2'b11, "lock during access");
    end
  end

  task automatic run(input logic [5:0] op3, input logic f, input logic [7:0] imm,
      input logic [63:0] a, input logic [63:0] c, input logic [63:0] nv,
      input logic [7:0] sr, input logic p);
    int n;
    @(posedge clk_i);
    req_i <= 1'b1;
    instr_i <= {OP_MEMORY, 5'h07, op3, 5'h01, f, imm, 5'h02};
    address_source_reg_i <= a;
    compare_source_reg_i <= c;
    dest_reg_i <= nv;
    space_reg_i <= sr;
    priv_i <= p;
    @(posedge clk_i);
    req_i <= 1'b0;
    got_done = 1'b0;
    for (n = 0; n < 40 && !got_done; n++) begin
      @(posedge clk_i);
      #1;
      if (done_o === 1'b1) begin
        got_done = 1'b1;
        {got_we, got_m, got_tf, got_idx} = {rd_we_o, match_o, trap_o, rd_idx_o};
        got_rd = rd_data_o;
        got_trap = trap_code_o;
      end
    end
    check(cc_we_o, 1'b0, "condition codes");
    check(busy_o, 1'b0, "idle after end");
    if (!got_done && (op3 == OP3_CAS_WORD || op3 == OP3_CAS_DWORD)) begin
      failures++;
      $display("ERROR %0t: no done", $time);
      summarize();
    end
  endtask

  task automatic expect_ok(input logic [63:0] rd, input logic m);
    check(64'(got_trap), 64'(TRAP_NONE), "trap code");
    check({got_we, got_tf, got_idx}, 7'h47, "rd write");
    check(got_rd, rd, "old value");
    check(got_m, m, "match");
  endtask

  task automatic tc(input logic [5:0] op3, input logic f, input logic [7:0] imm,
      input logic [63:0] a, input logic [7:0] sr, input logic p, input acsu_trap_t code);
    run(op3, f, imm, a, 64'h0, 64'h0, sr, p);
    check(64'(got_trap), 64'(code), "trap code");
    check({got_we, got_tf}, 2'b01, "trap pulse");
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // sreg left invalid: only the immediate field can make these legal
    {mem.w[2], mem.w[3]} = 64'h1357_9bdf_2468_ace0;
    run(OP3_CAS_DWORD, 1'b0, PRIMARY_SPACE, 64'h8, 64'h1357_9bdf_2468_ace0,
      64'haaaa_5555_cccc_3333, 8'h00, 1'b0);
    expect_ok(64'h1357_9bdf_2468_ace0, 1'b1);
    check({mem.w[2], mem.w[3]}, 64'haaaa_5555_cccc_3333, "dword swapped");
    s0 = mem.stores;
    lat = 4'h3;
    run(OP3_CAS_DWORD, 1'b0, PRIMARY_SPACE, 64'h8, 64'h2aaa_5555_cccc_3333, 64'h5,
      8'h00, 1'b0);
    lat = 4'h0;
    expect_ok(64'haaaa_5555_cccc_3333, 1'b0);
    check({mem.w[2], mem.w[3]}, 64'haaaa_5555_cccc_3333, "dword kept");
    check(64'(mem.stores - s0), 64'h1, "store on miss");
    $display("test dword done");
    mem.w[1] = 32'h7777_0001;
    run(OP3_CAS_WORD, 1'b0, KERNEL_SPACE, 64'h4, 64'hffff_ffff_7777_0001,
      64'h1234_5678_9abc_def0, 8'h00, 1'b1);
    expect_ok(64'h7777_0001, 1'b1);
    check(mem.w[1], 32'h9abc_def0, "word swapped");
    run(OP3_CAS_WORD, 1'b0, KERNEL_SPACE, 64'h4, 64'h9abc_def1, 64'hffff_0000_1111_2222,
      8'h00, 1'b1);
    expect_ok(64'h9abc_def0, 1'b0);
    check(mem.w[1], 32'h9abc_def0, "word kept");
    $display("test word done");
    run(OP3_CAS_DWORD, 1'b1, 8'h00, 64'h8, 64'haaaa_5555_cccc_3333, 64'h0102_0304_0506_0708,
      SECONDARY_SPACE, 1'b0);
    expect_ok(64'haaaa_5555_cccc_3333, 1'b1);
    run(OP3_CAS_DWORD, 1'b0, PRIMARY_SPACE_LE, 64'h8, 64'h0807_0605_0403_0201,
      64'h1111_2222_3333_4444, 8'h00, 1'b0);
    expect_ok(64'h0807_0605_0403_0201, 1'b1);
    check({mem.w[2], mem.w[3]}, 64'h4444_3333_2222_1111, "little store");
    for (int i = 0; i < 12; i++) begin
      run(OP3_CAS_DWORD, 1'b0, SPACES[i], 64'h8, 64'h0, 64'h0, 8'h00, 1'b1);
      check(64'(got_trap), 64'(TRAP_NONE), "space accepted");
    end
    $display("test space done");
    tc(OP3_CAS_WORD, 1'b1, 8'h01, 64'h4, PRIMARY_SPACE, 1'b0, TRAP_ILLEGAL);
    tc(OP3_CAS_WORD, 1'b0, PRIMARY_SPACE, 64'h6, 8'h00, 1'b0, TRAP_ALIGN);
    tc(OP3_CAS_DWORD, 1'b0, PRIMARY_SPACE, 64'h4, 8'h00, 1'b0, TRAP_ALIGN);
    tc(OP3_CAS_DWORD, 1'b0, KERNEL_SPACE, 64'h8, 8'h00, 1'b0, TRAP_PRIV);
    tc(OP3_CAS_DWORD, 1'b0, 8'h82, 64'h8, 8'h00, 1'b0, TRAP_ACCESS);
    tc(OP3_CAS_DWORD, 1'b0, 8'h30, 64'h8, 8'h00, 1'b1, TRAP_PRIV);
    tc(OP3_CAS_WORD, 1'b0, 8'h7f, 64'h4, 8'h00, 1'b1, TRAP_PRIV);
    tc(OP3_CAS_DWORD, 1'b0, 8'h2f, 64'h8, 8'h00, 1'b1, TRAP_ACCESS);
    tc(OP3_CAS_DWORD, 1'b1, 8'h00, 64'h8, 8'h30, 1'b1, TRAP_PRIV);
    $display("test traps done");
    s0 = mem.stores;
    err_ld = 1'b1;
    tc(OP3_CAS_DWORD, 1'b0, PRIMARY_SPACE, 64'h8, 8'h00, 1'b0, TRAP_ACCESS);
    err_ld = 1'b0;
    check(64'(mem.stores - s0), 64'h0, "no store after load error");
    err_st = 1'b1;
    tc(OP3_CAS_DWORD, 1'b0, PRIMARY_SPACE, 64'h8, 8'h00, 1'b0, TRAP_ACCESS);
    err_st = 1'b0;
    check({mem.w[2], mem.w[3]}, 64'h4444_3333_2222_1111, "memory kept");
    $display("test memerr done");
    run(6'h3d, 1'b0, PRIMARY_SPACE, 64'h8, 64'h0, 64'h0, 8'h00, 1'b0);
    check(got_done, 1'b0, "other opcode ignored");
    run(6'h3d, 1'b0, PRIMARY_SPACE, 64'h6, 64'h0, 64'h0, 8'h00, 1'b0);
    check(got_done, 1'b0, "other opcode no trap");
    $display("test opcode done");
    summarize();
  end
endmodule
